//--- hpsc_checker.sv
/* Port assertions for hpsc_top, bound below.
 Assumes the APB master keeps each request steady until pready. */
`include "hpsc_map.vh"
`default_nettype none
module hpsc_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`HPSC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Slot side
    input wire logic [1:0] attn_ind,
    input wire logic [1:0] pwr_ind,
    input wire logic slot_power_off,
    input wire logic attn_msg_valid,
    input wire logic [1:0] attn_msg_code,
    input wire logic pwr_msg_valid,
    input wire logic [1:0] pwr_msg_code,
    input wire logic hp_irq,
    input wire logic hp_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh_q;
    sequence wr_s;
        psel && penable && pready && pwrite && paddr == `HPSC_SLOT_ADDR;
    endsequence
    sequence setup_s;
        psel && !penable;
    endsequence
    // Shadow of the control half-word, so enables can be judged from the ports
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            sh_q <= `HPSC_CTL_RST;
        else if (psel && penable && pready && pwrite && paddr == `HPSC_SLOT_ADDR) begin
            if (pstrb[0])
                sh_q[7:0] <= pwdata[7:0];
            if (pstrb[1])
                sh_q[15:8] <= pwdata[15:8];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    attn_ind_a: assert property (wr_s ##0 pstrb[0] |=> attn_ind == $past(pwdata[7:6]))
        else $error("attention indicator not written");
    attn_msg_a: assert property (wr_s ##0 pstrb[0] |=> attn_msg_valid && attn_msg_code == $past(pwdata[7:6]))
        else $error("attention message missing");
    pwr_ind_a: assert property (wr_s ##0 pstrb[1] |=> pwr_ind == $past(pwdata[9:8]))
        else $error("power indicator not written");
    pwr_msg_a: assert property (wr_s ##0 pstrb[1] |=> pwr_msg_valid && pwr_msg_code == $past(pwdata[9:8]))
        else $error("power message missing");
    power_ctl_a: assert property (wr_s ##0 pstrb[1] |=> slot_power_off == $past(pwdata[10]))
        else $error("slot power bit not followed");
    irq_gate_a: assert property (!sh_q[5] && !$past(sh_q[5]) |-> !hp_irq)
        else $error("interrupt without master enable");
    wake_gate_a: assert property ((sh_q & 16'h100B) == 16'h0 && ($past(sh_q) & 16'h100B) == 16'h0 |-> !hp_wake)
        else $error("wake without an enable");
    ready_once_a: assert property (setup_s |=> pready ##1 !pready)
        else $error("pready not one access cycle");
    bad_addr_a: assert property (setup_s ##0 paddr != `HPSC_SLOT_ADDR |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule
bind hpsc_top hpsc_checker chk_u (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .attn_ind, .pwr_ind, .slot_power_off, .attn_msg_valid, .attn_msg_code,
    .pwr_msg_valid, .pwr_msg_code, .hp_irq, .hp_wake);
`default_nettype wire

//--- hpsc_map.vh
/*
 Register map, field positions, reset values and counts of the hot-plug slot
 control and status block. Definitions only; included by hpsc_top.v.
*/
`ifndef HPSC_MAP_VH
`define HPSC_MAP_VH

// Byte address of the shared control/status word
`define HPSC_ADDR_W 12
`define HPSC_SLOT_ADDR 12'h0D8

// Control half-word, bits 15:0
`define HPSC_C_ABP 0
`define HPSC_C_PFD 1
`define HPSC_C_PDC 3
`define HPSC_C_CCI 4
`define HPSC_C_HPI 5
`define HPSC_C_AIL 6
`define HPSC_C_AIH 7
`define HPSC_C_PIL 8
`define HPSC_C_PIH 9
`define HPSC_C_PCC 10
`define HPSC_C_DLC 12
`define HPSC_CTL_RST 16'h03C0
`define HPSC_CTL_WMASK 16'h17FB

// Status half-word, bits 31:16
`define HPSC_S_ABP 16
`define HPSC_S_PFD 17
`define HPSC_S_MRLC 18
`define HPSC_S_PDC 19
`define HPSC_S_CC 20
`define HPSC_S_MRLS 21
`define HPSC_S_PDS 22
`define HPSC_S_DLC 24
`define HPSC_DLC_RST 1'h1

// Indicator encodings
`define HPSC_IND_RSVD 2'h0
`define HPSC_IND_ON 2'h1
`define HPSC_IND_BLINK 2'h2
`define HPSC_IND_OFF 2'h3

// Synchronised pin inputs: index of each in the sync vector
`define HPSC_NSYNC 7
`define HPSC_I_BTN 0
`define HPSC_I_PFLT 1
`define HPSC_I_LATCH 2
`define HPSC_I_PRES 3
`define HPSC_I_STRAP 4
`define HPSC_I_SLOT 5
`define HPSC_I_CACK 6

// Cycles after reset release before the strap is taken (sync latency)
`define HPSC_STRAP_WAIT 2'h2

`endif

//--- hpsc_slot_model.sv
/* Slot hardware model: sensor pins set by the bench, command acknowledge.
 Assumes the indicator message pulses mark each issued command. */
`default_nettype none
module hpsc_slot_model (
    // Clock
    input wire logic core_clk,
    // Command watch and reply speed
    input wire logic msg_seen,
    input wire logic slow,
    // Pins: card, latch, fault, button
    output var logic [3:0] pins,
    output var logic cmd_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pins = 4'h0;
        cmd_ack = 1'b0;
    end
    // Acks of crowded commands merge; the controller only needs one rising edge
    always @(posedge core_clk) begin
        if (msg_seen) begin
            repeat (slow ? 20 : 2) @(posedge core_clk);
            cmd_ack <= 1'b1;
            repeat (3) @(posedge core_clk);
            cmd_ack <= 1'b0;
        end
    end
    task set_pin(input int idx, input logic v);
        @(posedge core_clk);
        pins[idx] <= v;
    endtask
endmodule
`default_nettype wire

//--- hpsc_sync.v
/*
 Two flip-flop synchroniser for a vector of independent level inputs.
 Assumes each bit is a slow level; multi-bit coherence is not kept.
*/
`default_nettype none

module hpsc_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Levels
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            // First stage is read only by the second stage
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate

endmodule

`default_nettype wire

//--- hpsc_top.v
/*
 Hot-plug slot control and status register word for one downstream port,
 reached over APB, with slot sensor inputs, indicator and power outputs,
 indicator message pulses and hot-plug interrupt / wakeup levels.
 Assumes slot pins are asynchronous, link_active comes from core_clk logic,
 and the message sender accepts a one-cycle pulse each clock.
*/
`include "hpsc_map.vh"
`default_nettype none

module hpsc_top (
    // Clock and reset
    input wire core_clk,
    input wire resetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`HPSC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // Slot sensors
    input wire attn_button,
    input wire power_fault,
    input wire latch_open,
    input wire card_present,
    input wire presence_strap,
    input wire slot_implemented,
    input wire cmd_ack,
    // Link state
    input wire link_active,
    // Slot outputs
    output wire [1:0] attn_ind,
    output wire [1:0] pwr_ind,
    output wire slot_power_off,
    // Indicator messages
    output reg attn_msg_valid,
    output reg [1:0] attn_msg_code,
    output reg pwr_msg_valid,
    output reg [1:0] pwr_msg_code,
    // Notification
    output reg hp_irq,
    output reg hp_wake
);

    // Reset release through two flops
    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Pin synchronisers
    wire [`HPSC_NSYNC-1:0] pin_raw;
    wire [`HPSC_NSYNC-1:0] pin_s;
    assign pin_raw = {cmd_ack, slot_implemented, presence_strap, card_present,
                      latch_open, power_fault, attn_button};

    hpsc_sync #(
        .W(`HPSC_NSYNC)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n_q),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    wire btn_s = pin_s[`HPSC_I_BTN];
    wire pflt_s = pin_s[`HPSC_I_PFLT];
    wire latch_s = pin_s[`HPSC_I_LATCH];
    wire pres_s = pin_s[`HPSC_I_PRES];
    wire strap_s = pin_s[`HPSC_I_STRAP];
    wire slot_s = pin_s[`HPSC_I_SLOT];
    wire cack_s = pin_s[`HPSC_I_CACK];

    // Previous values for edge detection, taken after the sync stage except link_prev_q, which samples link_active directly
    reg btn_prev_q;
    reg pflt_prev_q;
    reg latch_prev_q;
    reg cack_prev_q;
    reg link_prev_q;

    // Strap is taken once the synchroniser has filled
    reg [1:0] init_cnt_q;
    reg init_done_q;
    reg pres_state_q;

    // Registers
    reg [15:0] ctl_q;
    reg st_abp_q;
    reg st_pfd_q;
    reg st_mrlc_q;
    reg st_pdc_q;
    reg st_cc_q;
    reg st_dlc_q;
    reg cmd_busy_q;

    // APB decode
    wire setup = psel & ~penable;
    wire wr_fire = psel & penable & pready & pwrite;
    wire hit = (paddr == `HPSC_SLOT_ADDR);
    wire wr_ok = wr_fire & hit & ~pslverr;
    wire wr_lo = wr_ok & pstrb[0];
    wire wr_hi = wr_ok & pstrb[1];
    wire wr_ctl = wr_lo | wr_hi;

    // Write-one-to-clear strobes per status bit, except MRLC, which has none
    wire clr_abp = wr_ok & pstrb[2] & pwdata[`HPSC_S_ABP];
    wire clr_pfd = wr_ok & pstrb[2] & pwdata[`HPSC_S_PFD];
    wire clr_pdc = wr_ok & pstrb[2] & pwdata[`HPSC_S_PDC];
    wire clr_cc = wr_ok & pstrb[2] & pwdata[`HPSC_S_CC];
    wire clr_dlc = wr_ok & pstrb[3] & pwdata[`HPSC_S_DLC];

    // Events
    wire ev_btn = btn_s & ~btn_prev_q;
    wire ev_pflt = pflt_s & ~pflt_prev_q;
    wire ev_latch = init_done_q & (latch_s ^ latch_prev_q);
    wire pres_next = init_done_q ? pres_s : pres_state_q;
    wire ev_pres = init_done_q & (pres_next ^ pres_state_q);
    wire ev_cmd = cmd_busy_q & cack_s & ~cack_prev_q;
    wire ev_link = link_active ^ link_prev_q;

    // Presence as software sees it
    wire pres_read = slot_s ? pres_state_q : 1'b1;

    // Control word next value, honouring byte strobes
    reg [15:0] ctl_d;
    reg [15:0] wmask;
    always @* begin
        wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & `HPSC_CTL_WMASK;
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d = (ctl_q & ~wmask) | (pwdata[15:0] & wmask);
        end
    end

    // Read word assembled from live state
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h0000_0000;
        rd_word[15:0] = ctl_q & `HPSC_CTL_WMASK;
        rd_word[`HPSC_S_ABP] = st_abp_q;
        rd_word[`HPSC_S_PFD] = st_pfd_q;
        rd_word[`HPSC_S_MRLC] = st_mrlc_q;
        rd_word[`HPSC_S_PDC] = st_pdc_q;
        rd_word[`HPSC_S_CC] = st_cc_q;
        rd_word[`HPSC_S_MRLS] = latch_prev_q;
        rd_word[`HPSC_S_PDS] = pres_read;
        rd_word[`HPSC_S_DLC] = st_dlc_q;
    end

    // APB answer: one access cycle, data and error prepared during setup
    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= (hit && !pwrite) ? rd_word : 32'h0000_0000;
                pslverr <= ~hit;
            end else if (pready) begin
                pslverr <= 1'b0;
            end
        end
    end

    // Edge history and presence tracking
    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            btn_prev_q <= 1'b0;
            pflt_prev_q <= 1'b0;
            latch_prev_q <= 1'b0;
            cack_prev_q <= 1'b0;
            link_prev_q <= 1'b0;
            init_cnt_q <= 2'h0;
            init_done_q <= 1'b0;
            pres_state_q <= 1'b0;
        end else begin
            btn_prev_q <= btn_s;
            pflt_prev_q <= pflt_s;
            latch_prev_q <= latch_s;
            cack_prev_q <= cack_s;
            link_prev_q <= link_active;
            if (!init_done_q) begin
                // Strap level is only trusted after it passed both sync flops
                if (init_cnt_q == `HPSC_STRAP_WAIT) begin
                    init_done_q <= 1'b1;
                    pres_state_q <= ~strap_s;
                end else begin
                    init_cnt_q <= init_cnt_q + 2'h1;
                end
            end else begin
                pres_state_q <= pres_next;
            end
        end
    end

    // Control register
    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctl_q <= `HPSC_CTL_RST;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign attn_ind = ctl_q[`HPSC_C_AIH:`HPSC_C_AIL];
    assign pwr_ind = ctl_q[`HPSC_C_PIH:`HPSC_C_PIL];
    assign slot_power_off = ctl_q[`HPSC_C_PCC];

    // Indicator messages carry the value just written, reserved code included
    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            attn_msg_valid <= 1'b0;
            attn_msg_code <= `HPSC_IND_OFF;
            pwr_msg_valid <= 1'b0;
            pwr_msg_code <= `HPSC_IND_OFF;
        end else begin
            attn_msg_valid <= wr_lo;
            pwr_msg_valid <= wr_hi;
            if (wr_lo) begin
                attn_msg_code <= pwdata[`HPSC_C_AIH:`HPSC_C_AIL];
            end
            if (wr_hi) begin
                pwr_msg_code <= pwdata[`HPSC_C_PIH:`HPSC_C_PIL];
            end
        end
    end

    // Status flags: a set in the clearing cycle wins
    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_abp_q <= 1'b0;
            st_pfd_q <= 1'b0;
            st_mrlc_q <= 1'b0;
            st_pdc_q <= 1'b0;
            st_cc_q <= 1'b0;
            st_dlc_q <= `HPSC_DLC_RST;
            cmd_busy_q <= 1'b0;
        end else begin
            st_abp_q <= (st_abp_q & ~clr_abp) | ev_btn;
            st_pfd_q <= (st_pfd_q & ~clr_pfd) | ev_pflt;
            st_mrlc_q <= st_mrlc_q | ev_latch;
            st_pdc_q <= (st_pdc_q & ~clr_pdc) | ev_pres;
            st_cc_q <= (st_cc_q & ~clr_cc) | ev_cmd;
            st_dlc_q <= (st_dlc_q & ~clr_dlc) | ev_link;
            // A control write is a command; the slot's ack completes it
            if (wr_ctl) begin
                cmd_busy_q <= 1'b1;
            end else if (ev_cmd) begin
                cmd_busy_q <= 1'b0;
            end
        end
    end

    // Notification
    wire en_abp = st_abp_q & ctl_q[`HPSC_C_ABP];
    wire en_pfd = st_pfd_q & ctl_q[`HPSC_C_PFD];
    wire en_pdc = st_pdc_q & ctl_q[`HPSC_C_PDC];
    wire en_cc = st_cc_q & ctl_q[`HPSC_C_CCI];
    wire en_dlc = st_dlc_q & ctl_q[`HPSC_C_DLC];
    wire any_en = en_abp | en_pfd | en_pdc | en_cc | en_dlc;

    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hp_irq <= 1'b0;
            hp_wake <= 1'b0;
        end else begin
            hp_irq <= ctl_q[`HPSC_C_HPI] & any_en;
            // Wake does not need the master enable; command completion never wakes
            hp_wake <= en_abp | en_pfd | en_pdc | en_dlc;
        end
    end

endmodule

`default_nettype wire

//--- tb.sv
/* Register-level bench for hpsc_top over APB with a slot model.
 Assumes zero-wait APB answers but waits for pready under a limit. */
`include "hpsc_map.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, err_seen;
    logic presence_strap = 1, slot_impl = 1, link = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, acc;
    logic [3:0] pstrb = 4'h0;
    wire logic [3:0] pins;
    wire logic pready, pslverr, cmd_ack, amv, pmv, spo, irq, wake;
    wire logic [31:0] prdata;
    wire logic [1:0] ai, pi, ac, pc;
    int err_total = 0, cmp_count = 0;
    logic [31:0] ev[4] = '{32'h00010000, 32'h00020000, 32'h00240000, 32'h00480000};
    always #5 core_clk = ~core_clk;
    hpsc_slot_model slot_u (.core_clk(core_clk), .msg_seen(amv | pmv), .slow(slow), .pins(pins), .cmd_ack(cmd_ack));
    hpsc_top dut_u (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .attn_button(pins[0]), .power_fault(pins[1]), .latch_open(pins[2]), .card_present(pins[3]),
        .presence_strap(presence_strap), .slot_implemented(slot_impl), .cmd_ack(cmd_ack), .link_active(link),
        .attn_ind(ai), .pwr_ind(pi), .slot_power_off(spo), .attn_msg_valid(amv), .attn_msg_code(ac),
        .pwr_msg_valid(pmv), .pwr_msg_code(pc), .hp_irq(irq), .hp_wake(wake));
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input string nm, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, `HPSC_SLOT_ADDR, 32'h0, 4'h0);
        chk(nm, exp, rd & mask);
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task wrap_up;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        tick(10);
        rdchk("reset word", 32'hFFFFFFFF, 32'h010003C0);
        apb(1'b0, 12'h0DC, 32'h0, 4'h0);
        chk("unmapped err", 32'h1, {31'h0, err_seen});
        apb(1'b1, `HPSC_SLOT_ADDR, 32'h01000000, 4'h8);
        rdchk("link chg clear", 32'h01000000, 32'h0);
        for (int i = 1; i < 4; i++) begin
            slow <= (i == 2);
            apb(1'b1, `HPSC_SLOT_ADDR, {21'h0, i[0], i[1:0], i[1:0], 6'h0}, 4'h3);
            #1;
            chk("attn_ind", i, {30'h0, ai});
            chk("pwr_ind", i, {30'h0, pi});
            chk("power off", {31'h0, i[0]}, {31'h0, spo});
            tick(30);
            rdchk("cmd done", 32'h00100000, 32'h00100000);
            apb(1'b1, `HPSC_SLOT_ADDR, 32'h00100000, 4'h4);
            rdchk("cmd clear", 32'h00100000, 32'h0);
        end
        acc = 32'h0;
        for (int k = 0; k < 4; k++) begin
            slot_u.set_pin(k, 1'b1);
            acc = acc | ev[k];
            tick(8);
            rdchk("events", 32'h006F0000, acc);
        end
        apb(1'b1, `HPSC_SLOT_ADDR, 32'h011B0000, 4'hC);
        rdchk("sticky", 32'h017F0000, 32'h00640000);
        slot_u.set_pin(0, 1'b0);
        apb(1'b1, `HPSC_SLOT_ADDR, 32'h000007E1, 4'h3);
        slot_u.set_pin(0, 1'b1);
        tick(8);
        chk("irq on", 32'h1, {31'h0, irq});
        chk("wake on", 32'h1, {31'h0, wake});
        apb(1'b1, `HPSC_SLOT_ADDR, 32'h00010000, 4'h4);
        tick(3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, `HPSC_SLOT_ADDR, 32'h000007C1, 4'h3);
        slot_u.set_pin(0, 1'b0);
        tick(8);
        slot_u.set_pin(0, 1'b1);
        tick(8);
        chk("irq masked", 32'h0, {31'h0, irq});
        chk("wake kept", 32'h1, {31'h0, wake});
        apb(1'b1, `HPSC_SLOT_ADDR, 32'h01010000, 4'h4);
        apb(1'b1, `HPSC_SLOT_ADDR, 32'h000017C0, 4'h3);
        tick(3);
        chk("wake idle", 32'h0, {31'h0, wake});
        @(posedge core_clk);
        link <= 1'b1;
        tick(4);
        chk("wake link", 32'h1, {31'h0, wake});
        rdchk("link chg", 32'h01000000, 32'h01000000);
        slot_u.set_pin(3, 1'b0);
        tick(8);
        rdchk("slot empty", 32'h00400000, 32'h0);
        @(posedge core_clk);
        slot_impl <= 1'b0;
        tick(8);
        rdchk("no slot", 32'h00400000, 32'h00400000);
        // Strap low: presence starts at one, then drops to the empty slot
        @(posedge core_clk);
        resetn <= 1'b0;
        presence_strap <= 1'b0;
        slot_impl <= 1'b1;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        tick(10);
        rdchk("strap low", 32'h0048FFFF, 32'h000803C0);
        wrap_up();
    end
endmodule
`default_nettype wire
